// File: src/psl_status.v
// sequence recording status, overwrite status, rail order counter and level readout
// assumes: register port from the serial slave on sys_clk; pins are asynchronous
//
// Operation
// RL1: bit 7 high while a sequence records
// RL2: bits 6:5 give recorded sequence kind
// RL3: no overwrite: timestamp ready clears on ack
// RL4: overwrite: clears after enabled timestamps read
// RL5: ready plus active means timestamps being replaced
// RL6: four log ready flags clear on acks; the code clears them on acks only while log overwrite is off
// RL7: overwrite: log ready clears after enabled reads
// RL8: ready, active, matching kind means log overwritten
// RL9: timestamp lost flag on overwrite or drop
// RL10: per-sequence lost flags on overwrite or drop
// RL11: counter counts sync falls during sequences
// RL12: counter value is the channel order tag
// RL13: level code 5 mV steps from 0.2 V
// RL14: at 4x scaling, 20 mV steps from 0.8 V
// RL15: power-on log captures tags on rising request
// RL16: status registers read-only; acks are pulses
`timescale 1ns/100ps
`include "psl_defines.vh"

module psl_status (
  // clock and reset
  input  wire       sys_clk,
  input  wire       reset,
  // pins
  input  wire       power_on_request_pin,
  input  wire       sleep_pin,
  input  wire       sync_tag_n,
  input  wire [5:0] channel_good,
  // control bits held elsewhere
  input  wire       software_record_start,
  input  wire       timestamp_overwrite_enable,
  input  wire       log_overwrite_enable,
  input  wire [5:0] channel_enable_mask,
  input  wire       range_scaling_select,
  input  wire       timestamp_acknowledge,
  input  wire [3:0] log_acknowledge,
  // level sample
  input  wire       level_valid,
  input  wire [7:0] level_code,
  // register port
  input  wire       reg_rd,
  input  wire       reg_wr,
  input  wire [7:0] reg_addr,
  output reg  [7:0] reg_rdata_q,
  output wire       range_is_4x
);

  // three-stage synchronisers for the pins
  reg [2:0] act_s_q, slp_s_q, syn_s_q;
  reg       act_q, slp_q, syn_q;
  reg       recording_active_q;
  reg [1:0] recorded_phase_kind_q;
  reg       timestamp_ready_q, timestamp_lost_flag_q;
  reg [3:0] log_ready_q, log_lost_q;
  reg [7:0] order_count_q, level_q;
  reg [5:0] tagged_q, ts_read_q;
  reg [5:0] log_read_q [0:3];
  reg [5:0] good_s1_q, good_s2_q, good_s3_q, good_q;
  integer   i;
  integer   j;

  wire act_rise = ~act_q & act_s_q[1] & act_s_q[2];
  wire act_fall = act_q & ~act_s_q[1] & ~act_s_q[2];
  wire slp_rise = ~slp_q & slp_s_q[1] & slp_s_q[2];
  wire slp_fall = slp_q & ~slp_s_q[1] & ~slp_s_q[2];
  wire syn_fall = syn_q & ~syn_s_q[1] & ~syn_s_q[2];
  wire start    = act_rise | act_fall | slp_rise | slp_fall | software_record_start;
  wire done     = recording_active_q & ((tagged_q | ~channel_enable_mask) == `PSL_CH_ALL);
  wire [1:0] new_kind = act_rise ? `PSL_KIND_ON  : act_fall ? `PSL_KIND_OFF :
                        slp_rise ? `PSL_KIND_EXS : slp_fall ? `PSL_KIND_ENS :
                        `PSL_KIND_ON;

  // kind to one-hot flag position: bit 3 power on down to bit 0 sleep entry
  function [3:0] kind_bit;
    input [1:0] k;
    kind_bit = 4'h8 >> k;
  endfunction

  function [2:0] ch_of;
    input [7:0] a;
    input [7:0] base;
    ch_of = a[2:0] - base[2:0];
  endfunction

  // capture the current tag for each enabled channel as it comes good
  // one channel per cycle, so channels that go good together each get their tag written while can_store is high
  wire [5:0] new_good = good_q & ~tagged_q & channel_enable_mask;
  reg  [2:0] wr_ch;
  reg  [5:0] wr_bit;
  always @* begin
    wr_ch = 3'h0;
    wr_bit = 6'h00;
    for (j = `PSL_NUM_CH - 1; j >= 0; j = j - 1) begin
      if (new_good[j]) begin
        wr_ch = j[2:0];
        wr_bit = 6'h01 << j;
      end
    end
  end
  wire       can_store = log_overwrite_enable | ~log_ready_q[3 - recorded_phase_kind_q];
  wire       mem_we    = recording_active_q & (|new_good) & can_store;
  wire       in_log    = (reg_addr >= `PSL_ADDR_ON_LOG) & (reg_addr < (`PSL_ADDR_ENS_LOG + 8'h06));
  wire       in_ts     = (reg_addr >= `PSL_ADDR_TS_BASE) &
                         (reg_addr < (`PSL_ADDR_TS_BASE + 8'h06));
  wire [7:0] log_off   = reg_addr - `PSL_ADDR_ON_LOG;
  wire [1:0] rd_kind   = log_off[4:3];

  // read port left open: the log bytes are answered outside this status block
  psl_order_mem u_mem (
    .sys_clk   (sys_clk),
    .wr_en     (mem_we),
    .wr_addr   ({recorded_phase_kind_q, wr_ch}),
    .wr_data   (order_count_q), // RL12 RL15
    .rd_addr   ({rd_kind, reg_addr[2:0]}),
    .rd_data_q ()
  );

  assign range_is_4x = range_scaling_select; // RL13 RL14

  always @(posedge sys_clk) begin
    if (reset) begin
      act_s_q <= 3'h0;
      slp_s_q <= 3'h0;
      syn_s_q <= 3'h7;
      act_q <= 1'b0;
      slp_q <= 1'b0;
      syn_q <= 1'b1;
      good_s1_q <= 6'h00;
      good_s2_q <= 6'h00;
      good_s3_q <= 6'h00;
      good_q <= 6'h00;
      recording_active_q <= 1'b0;
      recorded_phase_kind_q <= `PSL_KIND_ON;
      timestamp_ready_q <= 1'b0;
      timestamp_lost_flag_q <= 1'b0;
      log_ready_q <= 4'h0;
      log_lost_q <= 4'h0;
      order_count_q <= `PSL_ORDER_ZERO;
      level_q <= `PSL_ORDER_ZERO;
      tagged_q <= 6'h00;
      ts_read_q <= 6'h00;
      for (i = 0; i < 4; i = i + 1) log_read_q[i] <= 6'h00;
    end else begin
      // a pin change counts once two stages agree, so one glitch cannot start a sequence
      act_s_q <= {act_s_q[1:0], power_on_request_pin};
      slp_s_q <= {slp_s_q[1:0], sleep_pin};
      syn_s_q <= {syn_s_q[1:0], sync_tag_n};
      good_s1_q <= channel_good;
      good_s2_q <= good_s1_q;
      good_s3_q <= good_s2_q;
      good_q <= (good_s2_q & good_s3_q) | (good_q & (good_s2_q | good_s3_q));
      if (act_s_q[1] == act_s_q[2]) act_q <= act_s_q[2];
      if (slp_s_q[1] == slp_s_q[2]) slp_q <= slp_s_q[2];
      if (syn_s_q[1] == syn_s_q[2]) syn_q <= syn_s_q[2];
      if (level_valid) level_q <= level_code; // RL13
      // start of a sequence; a new start restarts recording
      if (start) begin
        recording_active_q <= 1'b1; // RL1
        recorded_phase_kind_q <= new_kind; // RL2
        order_count_q <= `PSL_ORDER_ZERO;
        tagged_q <= 6'h00;
      end else if (done) begin
        recording_active_q <= 1'b0; // RL1
        // completion sets ready unless ready is still set without overwrite; a set wins over any clear this cycle
        if (timestamp_ready_q) timestamp_lost_flag_q <= 1'b1; // RL9
        if (log_ready_q[3 - recorded_phase_kind_q])
          log_lost_q <= log_lost_q | kind_bit(recorded_phase_kind_q); // RL10
      end else if (recording_active_q) begin
        if (syn_fall) order_count_q <= order_count_q + `PSL_ORDER_ONE; // RL11
        tagged_q <= tagged_q | wr_bit; // RL15
      end
      // timestamp ready
      if (done & (timestamp_overwrite_enable | ~timestamp_ready_q)) begin
        timestamp_ready_q <= 1'b1; // RL5
        ts_read_q <= 6'h00;
      end else if (~timestamp_overwrite_enable & timestamp_acknowledge) begin
        timestamp_ready_q <= 1'b0; // RL3 RL16
      end else if (timestamp_overwrite_enable &
                   ((ts_read_q | ~channel_enable_mask) == `PSL_CH_ALL)) begin
        timestamp_ready_q <= 1'b0; // RL4
      end else if (reg_rd & in_ts) begin
        ts_read_q[reg_addr[2:0]] <= 1'b1;
      end
      // log ready flags
      for (i = 0; i < 4; i = i + 1) begin
        if (done & (kind_bit(recorded_phase_kind_q) == (4'h1 << i)) &
            (log_overwrite_enable | ~log_ready_q[i])) begin
          log_ready_q[i] <= 1'b1; // RL8
          log_read_q[3 - i] <= 6'h00;
        end else if (~log_overwrite_enable & log_acknowledge[i]) begin
          log_ready_q[i] <= 1'b0; // RL6 RL16
        end else if (log_overwrite_enable &
                     ((log_read_q[3 - i] | ~channel_enable_mask) == `PSL_CH_ALL)) begin
          log_ready_q[i] <= 1'b0; // RL7
        end
      end
      if (reg_rd & in_log & (reg_addr[2:0] < 3'h6))
        log_read_q[rd_kind][reg_addr[2:0]] <= 1'b1;
    end
  end

  // register read mux; writes to these addresses are ignored
  always @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata_q <= `PSL_ORDER_ZERO;
    end else if (reg_rd) begin
      if (reg_addr == `PSL_ADDR_REC_STAT)
        reg_rdata_q <= {recording_active_q, recorded_phase_kind_q,
                        timestamp_ready_q, log_ready_q}; // RL1 RL2 RL6
      else if (reg_addr == `PSL_ADDR_OW_STAT)
        reg_rdata_q <= {3'h0, timestamp_lost_flag_q, log_lost_q}; // RL9 RL10
      else if (reg_addr == `PSL_ADDR_ORDER)
        reg_rdata_q <= order_count_q; // RL11
      else if (reg_addr == `PSL_ADDR_LEVEL1)
        reg_rdata_q <= level_q;
      else
        reg_rdata_q <= `PSL_ORDER_ZERO;
    end
  end

endmodule // psl_status

// File: src/psl_defines.vh
// register offsets, field positions and codes of the sequence logging status block
// assumes: included by the status block and its order memory
`ifndef PSL_DEFINES_VH
`define PSL_DEFINES_VH

`define PSL_ADDR_REC_STAT   8'h34
`define PSL_ADDR_OW_STAT    8'h35
`define PSL_ADDR_ORDER      8'h36
`define PSL_ADDR_LEVEL1     8'h40
`define PSL_ADDR_TS_BASE    8'h20
`define PSL_ADDR_ON_LOG     8'h50
`define PSL_ADDR_OFF_LOG    8'h58
`define PSL_ADDR_EXS_LOG    8'h60
`define PSL_ADDR_ENS_LOG    8'h68

`define PSL_BIT_ACTIVE      7
`define PSL_BIT_KIND_HI     6
`define PSL_BIT_KIND_LO     5
`define PSL_BIT_TS          4

`define PSL_KIND_ON         2'h0
`define PSL_KIND_OFF        2'h1
`define PSL_KIND_EXS        2'h2
`define PSL_KIND_ENS        2'h3

`define PSL_NUM_CH          6
`define PSL_CH_ALL          6'h3f
`define PSL_ORDER_ZERO      8'h00
`define PSL_ORDER_ONE       8'h01
`define PSL_SYNC_STAGES     3

`endif

// File: src/psl_order_mem.v
// order log memory: four sequences by six channels, 8-bit tags
// assumes: single clock, one write and one registered read per cycle
`timescale 1ns/100ps
`include "psl_defines.vh"

module psl_order_mem (
  // clock
  input  wire       sys_clk,
  // write port
  input  wire       wr_en,
  input  wire [4:0] wr_addr,
  input  wire [7:0] wr_data,
  // read port
  input  wire [4:0] rd_addr,
  output reg  [7:0] rd_data_q
);

  reg [7:0] mem [0:31];

  // contents need no reset; the ready flags say when a log is valid
  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end

endmodule // psl_order_mem

// File: tb/psl_status_checker.sv
// assertions on the status block ports
// assumes: bound to psl_status, one clock
`timescale 1ns/100ps
module psl_status_checker (
  // clock, reset, controls
  input wire       sys_clk,
  input wire       reset,
  input wire       timestamp_overwrite_enable,
  input wire       log_overwrite_enable,
  input wire       range_scaling_select,
  input wire       timestamp_acknowledge,
  input wire [3:0] log_acknowledge,
  input wire       level_valid,
  input wire [7:0] level_code,
  // register port
  input wire       reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata_q,
  input wire       range_is_4x
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  chk_scale_copy: assert property (range_is_4x == range_scaling_select)
    else $error("scale flag wrong");
  chk_unmapped_zero: assert property (reg_rd && reg_addr inside {[8'h37:8'h3f]}
    |=> reg_rdata_q == 8'h00) else $error("unmapped read not zero");
  chk_data_holds: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved");
  chk_level_read: assert property (level_valid ##1 (reg_rd && reg_addr == 8'h40
    && !level_valid) |=> reg_rdata_q == $past(level_code, 2)) else $error("level wrong");
  chk_lost_rsvd: assert property (reg_rd && reg_addr == 8'h35 |=> reg_rdata_q[7:5] == 3'h0)
    else $error("reserved lost bits set");
  chk_timestamp_acknowledge: assert property (timestamp_acknowledge && !timestamp_overwrite_enable
    ##1 (reg_rd && reg_addr == 8'h34) |=> !reg_rdata_q[4]) else $error("ts ready kept");
  chk_on_ack: assert property (log_acknowledge[3] && !log_overwrite_enable
    ##1 (reg_rd && reg_addr == 8'h34) |=> !reg_rdata_q[3]) else $error("on ready kept");
  chk_ens_ack: assert property (log_acknowledge[0] && !log_overwrite_enable
    ##1 (reg_rd && reg_addr == 8'h34) |=> !reg_rdata_q[0]) else $error("entry ready kept");
endmodule // psl_status_checker

// File: tb/psl_host_model.sv
// host side of the register port
// assumes: a read is answered one cycle after it is taken
`timescale 1ns/100ps
module psl_host_model (
  // clock
  input  wire       sys_clk,
  // register port
  output reg        reg_rd = 1'h0,
  output reg        reg_wr = 1'h0,
  output reg  [7:0] reg_addr = 8'h00,
  input  wire [7:0] reg_rdata_q
);
  // address inverted after release so a late sample cannot alias
  task rd(input [7:0] a, output [7:0] v);
    begin
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      reg_addr <= ~a;
      @(negedge sys_clk);
      v = reg_rdata_q;
      @(posedge sys_clk);
    end
  endtask
  task wr(input [7:0] a);
    begin
      reg_wr <= 1'h1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
      reg_addr <= ~a;
      @(posedge sys_clk);
    end
  endtask
endmodule // psl_host_model

// File: tb/psl_status_tb.sv
// bench for the status block: pins driven here, host model on the register port
// assumes: design, host model and checker compiled first
`timescale 1ns/100ps
module psl_status_tb;
  reg        sys_clk = 1'h0, reset = 1'h1, power_on_request_pin = 1'h0, sleep_pin = 1'h0;
  reg        sync_tag_n = 1'h1, software_record_start = 1'h0, level_valid = 1'h0;
  reg        timestamp_overwrite_enable = 1'h0, log_overwrite_enable = 1'h0;
  reg        range_scaling_select = 1'h0, timestamp_acknowledge = 1'h0;
  reg  [5:0] channel_good = 6'h00, channel_enable_mask = 6'h3f;
  reg  [3:0] log_acknowledge = 4'h0;
  reg  [7:0] level_code = 8'h00, d;
  reg  [9:0] tbl [0:4];
  wire       reg_rd, reg_wr, range_is_4x;
  wire [7:0] reg_addr, reg_rdata_q;
  integer    n_errors = 0, comparisons = 0, i;
  always #25 sys_clk = ~sys_clk;
  psl_status psl_status_i (
    .sys_clk                    (sys_clk),
    .reset                      (reset),
    .power_on_request_pin       (power_on_request_pin),
    .sleep_pin                  (sleep_pin),
    .sync_tag_n                 (sync_tag_n),
    .channel_good               (channel_good),
    .software_record_start      (software_record_start),
    .timestamp_overwrite_enable (timestamp_overwrite_enable),
    .log_overwrite_enable       (log_overwrite_enable),
    .channel_enable_mask        (channel_enable_mask),
    .range_scaling_select       (range_scaling_select),
    .timestamp_acknowledge      (timestamp_acknowledge),
    .log_acknowledge            (log_acknowledge),
    .level_valid                (level_valid),
    .level_code                 (level_code),
    .reg_rd                     (reg_rd),
    .reg_wr                     (reg_wr),
    .reg_addr                   (reg_addr),
    .reg_rdata_q                (reg_rdata_q),
    .range_is_4x                (range_is_4x)
  );
  psl_host_model psl_host_model_i (
    .sys_clk     (sys_clk),
    .reg_rd      (reg_rd),
    .reg_wr      (reg_wr),
    .reg_addr    (reg_addr),
    .reg_rdata_q (reg_rdata_q)
  );
  task summarize;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task check(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task w(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  task rc(input [7:0] a, input [7:0] e);
    begin
      psl_host_model_i.rd(a, d);
      check($sformatf("reg %h", a), d, e);
    end
  endtask
  // hang guard
  initial begin
    w(20000);
    n_errors = n_errors + 1;
    summarize;
  end
  initial begin
    // rows: request pin, sleep pin, status expected while recording
    tbl[0] = {2'h2, 8'h80};
    tbl[1] = {2'h0, 8'hb8};
    tbl[2] = {2'h1, 8'hdc};
    tbl[3] = {2'h0, 8'hfe};
    tbl[4] = {2'h2, 8'h9f};
    w(8);
    reset <= 1'h0;
    w(1);
    rc(8'h35, 8'h00);
    rc(8'h36, 8'h00);
    rc(8'h37, 8'h00);
    for (i = 0; i < 5; i = i + 1) begin
      {power_on_request_pin, sleep_pin} <= tbl[i][9:8];
      w(8);
      rc(8'h34, tbl[i][7:0]);
      channel_good <= 6'h3f;
      w(16);
      channel_good <= 6'h00;
      w(4);
    end
    rc(8'h34, 8'h1f);
    rc(8'h35, 8'h18);
    timestamp_acknowledge <= 1'h1;
    log_acknowledge <= 4'h9;
    w(1);
    timestamp_acknowledge <= 1'h0;
    log_acknowledge <= 4'h0;
    rc(8'h34, 8'h06);
    log_acknowledge <= 4'h6;
    w(1);
    log_acknowledge <= 4'h0;
    rc(8'h34, 8'h00);
    psl_host_model_i.wr(8'h35);
    rc(8'h35, 8'h18);
    timestamp_overwrite_enable <= 1'h1;
    log_overwrite_enable <= 1'h1;
    channel_enable_mask <= 6'h01;
    software_record_start <= 1'h1;
    w(1);
    software_record_start <= 1'h0;
    repeat (3) begin
      sync_tag_n <= 1'h0;
      w(2);
      sync_tag_n <= 1'h1;
      w(2);
    end
    w(6);
    rc(8'h36, 8'h03);
    rc(8'h34, 8'h80);
    channel_good <= 6'h3f;
    w(8);
    rc(8'h34, 8'h18);
    psl_host_model_i.rd(8'h20, d);
    rc(8'h34, 8'h08);
    psl_host_model_i.rd(8'h50, d);
    rc(8'h34, 8'h00);
    level_valid <= 1'h1;
    level_code <= 8'ha5;
    w(1);
    level_valid <= 1'h0;
    rc(8'h40, 8'ha5);
    range_scaling_select <= 1'h1;
    w(1);
    check("scale", {7'h00, range_is_4x}, 8'h01);
    summarize;
  end
endmodule // psl_status_tb
bind psl_status psl_status_checker psl_status_checker_i (
  .sys_clk                    (sys_clk),
  .reset                      (reset),
  .timestamp_overwrite_enable (timestamp_overwrite_enable),
  .log_overwrite_enable       (log_overwrite_enable),
  .range_scaling_select       (range_scaling_select),
  .timestamp_acknowledge      (timestamp_acknowledge),
  .log_acknowledge            (log_acknowledge),
  .level_valid                (level_valid),
  .level_code                 (level_code),
  .reg_rd                     (reg_rd),
  .reg_addr                   (reg_addr),
  .reg_rdata_q                (reg_rdata_q),
  .range_is_4x                (range_is_4x)
);
